// [hdl/ssa_top.v]
// stereo serial audio channel buffers: apb register slave, transmit fifo,
// serial receive and transmit of left and right samples
// assumes an external codec drives bit clock and word select; both are
// sampled by pclk, which must run well above twice the bit clock rate
//
// How it works
// RULE_01 - left rx register reads last left sample
// RULE_02 - left tx write supplies sample for shifting
// RULE_03 - right rx register reads last right sample
// RULE_04 - right tx write supplies sample to send
// RULE_05 - rx enable bit zero, resets off
// RULE_06 - word select phase 16, 24, 32 bits
// RULE_07 - received word lsb lands in bit 0
// RULE_08 - transmit msb first at programmed length
// RULE_09 - disabled receiver holds registers; reserved bits zero
`timescale 1ns/1ps
`include "ssa_regs.vh"

// ----------------------------------------
// transmit fifo
// ----------------------------------------
module ssa_fifo #(
  parameter WIDTH = `SSA_FIFO_WIDTH,
  parameter DEPTH = `SSA_FIFO_DEPTH,
  parameter AW = `SSA_FIFO_AW
) (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire in_valid, // push request
  output wire in_ready, // room for a word
  input wire [WIDTH-1:0] in_data, // word pushed
  output wire out_valid, // word available
  input wire out_ready, // pop request
  output wire [WIDTH-1:0] out_data, // head word
  output reg [AW:0] level // words held
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  wire push;
  wire pop;

  // handshakes on both sides
  assign in_ready = (level != DEPTH[AW:0]);
  assign out_valid = (level != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage array, no reset needed
  always @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and fill level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule // ssa_fifo

// ----------------------------------------
// top: registers and serial link
// ----------------------------------------
module ssa_top (
  input wire pclk, // system clock, 100 MHz
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction, high for write
  input wire [7:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb transfer done
  output reg pslverr, // apb error on unmapped address
  input wire link_sclk, // bit clock from codec
  input wire word_select_line, // low left, high right
  input wire link_sdi, // serial receive data
  output reg link_sdo // serial transmit data
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg [15:0] left_rx_buffer, right_rx_buffer, left_tx_holding, tx_right_hold;
  reg rx_channel_on;
  reg [1:0] word_select_span;
  reg [2:0] rx_sample_resolution, tx_sample_resolution;
  reg span_err, tx_underrun;
  reg [2:0] sclk_sync, ws_sync, sdi_sync;
  reg sclk_f, ws_f, sdi_f, sclk_d, ws_prev;
  reg [31:0] rx_sh, tx_sh;
  reg [5:0] rx_cnt, tx_cnt;
  reg [31:0] next_rdata, next_rx_word;
  reg next_hit;
  wire acc, wr_en, stall, fifo_in_ready, fifo_out_valid, fifo_pop, span_set, underrun_set;
  wire [31:0] fifo_out_data;
  wire [4:0] fifo_level;
  wire sclk_rise, sclk_fall, ws_chg;
  wire [5:0] rx_tot, rx_res, tx_res, span_bits, tx_limit;

  // resolution code to bit count, zero means ignore
  function [5:0] res_bits;
    input [2:0] code;
    begin
      case (code)
        `SSA_RES_12: res_bits = 6'h0c;
        `SSA_RES_16: res_bits = 6'h10;
        `SSA_RES_20: res_bits = 6'h14;
        `SSA_RES_24: res_bits = 6'h18;
        `SSA_RES_32: res_bits = 6'h20;
        default: res_bits = 6'h00;
      endcase
    end
  endfunction

  // sample placed msb first in a word of res bits
  function [31:0] tx_place;
    input [15:0] sample;
    input [5:0] res;
    begin
      tx_place = {16'h0000, sample} << (6'h20 - res);
    end
  endfunction

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign acc = psel & penable;
  assign wr_en = acc & pready & pwrite;
  // right write waits while the fifo is full
  assign stall = pwrite & (paddr == `SSA_OFF_RIGHT) & ~fifo_in_ready;

  // read mux and address decode
  always @* begin
    next_rdata = 32'h0000_0000;
    next_hit = 1'b1;
    case (paddr)
      `SSA_OFF_SPAN: next_rdata[`SSA_SPAN_MSB:`SSA_SPAN_LSB] = word_select_span;
      `SSA_OFF_LEFT: next_rdata[15:0] = left_rx_buffer; // RULE_01
      `SSA_OFF_RIGHT: next_rdata[15:0] = right_rx_buffer; // RULE_03
      `SSA_OFF_RXEN: next_rdata[0] = rx_channel_on;
      `SSA_OFF_STAT: begin
        next_rdata[`SSA_STAT_SPAN_ERR] = span_err;
        next_rdata[`SSA_STAT_UNDERRUN] = tx_underrun;
        next_rdata[`SSA_STAT_FULL] = ~fifo_in_ready;
        next_rdata[12:8] = fifo_level;
      end
      `SSA_OFF_RXRES: next_rdata[`SSA_RES_MSB:0] = rx_sample_resolution;
      `SSA_OFF_TXRES: next_rdata[`SSA_RES_MSB:0] = tx_sample_resolution;
      default: next_hit = 1'b0;
    endcase
  end

  // answer one cycle into the access phase unless stalled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (acc && !pready && !stall) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : next_rdata; // RULE_09
      pslverr <= ~next_hit;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // software writable registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_tx_holding <= `SSA_SAMPLE_RST;
      rx_channel_on <= `SSA_RXEN_RST;
      word_select_span <= `SSA_SPAN_RST;
      rx_sample_resolution <= `SSA_RES_RST;
      tx_sample_resolution <= `SSA_RES_RST;
    end else if (wr_en) begin
      case (paddr)
        `SSA_OFF_SPAN: word_select_span <= pwdata[`SSA_SPAN_MSB:`SSA_SPAN_LSB];
        `SSA_OFF_LEFT: left_tx_holding <= pwdata[15:0]; // RULE_02
        `SSA_OFF_RXEN: rx_channel_on <= pwdata[0]; // RULE_05
        `SSA_OFF_RXRES: rx_sample_resolution <= pwdata[`SSA_RES_MSB:0];
        `SSA_OFF_TXRES: tx_sample_resolution <= pwdata[`SSA_RES_MSB:0];
        default: left_tx_holding <= left_tx_holding;
      endcase
    end
  end

  // ----------------------------------------
  // transmit fifo, one left and right pair a word
  // ----------------------------------------
  ssa_fifo #(
    .WIDTH(`SSA_FIFO_WIDTH),
    .DEPTH(`SSA_FIFO_DEPTH),
    .AW(`SSA_FIFO_AW)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(wr_en & (paddr == `SSA_OFF_RIGHT)), // RULE_04
    .in_ready(fifo_in_ready),
    .in_data({left_tx_holding, pwdata[15:0]}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // ----------------------------------------
  // link input synchronisers
  // ----------------------------------------
  // three stages; a change counts once stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_sync <= 3'h0;
      ws_sync <= 3'h0;
      sdi_sync <= 3'h0;
      sclk_f <= 1'b0;
      ws_f <= 1'b0;
      sdi_f <= 1'b0;
      sclk_d <= 1'b0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], link_sclk};
      ws_sync <= {ws_sync[1:0], word_select_line};
      sdi_sync <= {sdi_sync[1:0], link_sdi};
      if (sclk_sync[1] == sclk_sync[2]) begin
        sclk_f <= sclk_sync[2];
      end
      if (ws_sync[1] == ws_sync[2]) begin
        ws_f <= ws_sync[2];
      end
      if (sdi_sync[1] == sdi_sync[2]) begin
        sdi_f <= sdi_sync[2];
      end
      sclk_d <= sclk_f;
    end
  end

  // bit clock edges as one-cycle enables
  assign sclk_rise = sclk_f & ~sclk_d;
  assign sclk_fall = ~sclk_f & sclk_d;
  assign ws_chg = sclk_rise & (ws_f != ws_prev);

  // ----------------------------------------
  // receive path
  // ----------------------------------------
  assign rx_tot = (rx_cnt == `SSA_MAX_BITS) ? rx_cnt : rx_cnt + 6'h01;
  assign rx_res = (res_bits(rx_sample_resolution) == 6'h00) ? rx_tot : res_bits(rx_sample_resolution);
  // phase length allowed by the span field
  assign span_bits = (word_select_span == `SSA_SPAN_16) ? 6'h10 :
                     (word_select_span == `SSA_SPAN_24) ? 6'h18 : 6'h20;
  assign span_set = ws_chg & (rx_tot > span_bits); // RULE_06

  // keep the first res bits, lsb into bit 0
  always @* begin
    next_rx_word = {rx_sh[30:0], sdi_f};
    if (rx_tot >= rx_res) begin
      next_rx_word = next_rx_word >> (rx_tot - rx_res); // RULE_07
    end else begin
      next_rx_word = next_rx_word << (rx_res - rx_tot);
    end
  end

  // shift on rising bit clock; last bit arrives with the ws change
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ws_prev <= 1'b0;
      rx_sh <= 32'h0000_0000;
      rx_cnt <= 6'h00;
      left_rx_buffer <= `SSA_SAMPLE_RST;
      right_rx_buffer <= `SSA_SAMPLE_RST;
    end else if (sclk_rise) begin
      ws_prev <= ws_f;
      if (ws_chg) begin
        rx_sh <= 32'h0000_0000;
        rx_cnt <= 6'h00;
        if (rx_channel_on && !ws_prev) begin // RULE_09
          left_rx_buffer <= next_rx_word[15:0]; // RULE_01
        end
        if (rx_channel_on && ws_prev) begin // RULE_05
          right_rx_buffer <= next_rx_word[15:0]; // RULE_03
        end
      end else begin
        rx_sh <= {rx_sh[30:0], sdi_f};
        rx_cnt <= rx_tot;
      end
    end
  end

  // ----------------------------------------
  // transmit path
  // ----------------------------------------
  assign tx_res = (res_bits(tx_sample_resolution) == 6'h00) ? 6'h10 : res_bits(tx_sample_resolution);
  assign tx_limit = (tx_res < span_bits) ? tx_res : span_bits; // RULE_06
  assign fifo_pop = ws_chg & ~ws_f & fifo_out_valid;
  assign underrun_set = ws_chg & ~ws_f & ~fifo_out_valid;

  // load on ws change, drive msb on the next falling bit clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh <= 32'h0000_0000;
      tx_cnt <= `SSA_MAX_BITS;
      tx_right_hold <= `SSA_SAMPLE_RST;
      link_sdo <= 1'b0;
    end else if (ws_chg) begin
      tx_cnt <= 6'h00;
      if (!ws_f) begin
        tx_sh <= fifo_out_valid ? tx_place(fifo_out_data[31:16], tx_res) : 32'h0000_0000; // RULE_02
        tx_right_hold <= fifo_out_valid ? fifo_out_data[15:0] : `SSA_SAMPLE_RST;
      end else begin
        tx_sh <= tx_place(tx_right_hold, tx_res); // RULE_04
      end
    end else if (sclk_fall) begin
      if (tx_cnt < tx_limit) begin
        link_sdo <= tx_sh[31]; // RULE_08
        tx_sh <= {tx_sh[30:0], 1'b0};
        tx_cnt <= tx_cnt + 6'h01;
      end else begin
        link_sdo <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // sticky status, write one to clear, set wins
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      span_err <= 1'b0;
      tx_underrun <= 1'b0;
    end else begin
      span_err <= span_set |
        (span_err & ~(wr_en & (paddr == `SSA_OFF_STAT) & pwdata[`SSA_STAT_SPAN_ERR]));
      tx_underrun <= underrun_set |
        (tx_underrun & ~(wr_en & (paddr == `SSA_OFF_STAT) & pwdata[`SSA_STAT_UNDERRUN]));
    end
  end
endmodule // ssa_top

// [hdl/ssa_regs.vh]
// register map, field positions, reset values and link constants
// of the stereo serial audio channel block; definitions only
`ifndef SSA_REGS_VH
`define SSA_REGS_VH

// ----------------------------------------
// register byte offsets (apb, 8-bit address)
// ----------------------------------------
`define SSA_OFF_SPAN 8'h10
`define SSA_OFF_LEFT 8'h20
`define SSA_OFF_RIGHT 8'h24
`define SSA_OFF_RXEN 8'h28
`define SSA_OFF_STAT 8'h2c
`define SSA_OFF_RXRES 8'h30
`define SSA_OFF_TXRES 8'h34

// ----------------------------------------
// field positions
// ----------------------------------------
`define SSA_SPAN_MSB 4
`define SSA_SPAN_LSB 3
`define SSA_SAMPLE_MSB 15
`define SSA_RES_MSB 2
`define SSA_STAT_SPAN_ERR 0
`define SSA_STAT_UNDERRUN 1
`define SSA_STAT_FULL 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define SSA_SPAN_RST 2'h0
`define SSA_RES_RST 3'h2
`define SSA_RXEN_RST 1'h0
`define SSA_SAMPLE_RST 16'h0000

// ----------------------------------------
// encodings of word select span and sample resolution
// ----------------------------------------
`define SSA_SPAN_16 2'h0
`define SSA_SPAN_24 2'h1
`define SSA_RES_IGNORE 3'h0
`define SSA_RES_12 3'h1
`define SSA_RES_16 3'h2
`define SSA_RES_20 3'h3
`define SSA_RES_24 3'h4
`define SSA_RES_32 3'h5

// ----------------------------------------
// widths, depths and bit counts
// ----------------------------------------
`define SSA_FIFO_WIDTH 32
`define SSA_FIFO_DEPTH 16
`define SSA_FIFO_AW 4
`define SSA_MAX_BITS 6'h20

`endif

// [verification/ssa_properties.sv]
// port checker of ssa_top: apb answer timing, error flags, reserved bits, link timing
// assumes one pclk domain with presetn asynchronous, active low
`timescale 1ns/1ps
module ssa_props (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction
  input wire [7:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  input wire [31:0] prdata, // apb read data
  input wire pready, // apb transfer done
  input wire pslverr, // apb error
  input wire link_sclk, // bit clock
  input wire word_select_line, // word select
  input wire link_sdi, // serial receive data
  input wire link_sdo // serial transmit data
);
  // ----
  // clocking, address decode, transfer steps
  // ----
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_ok = pready && !pwrite;
  wire mapped = paddr == 8'h10 || paddr == 8'h20 || paddr == 8'h24 || paddr == 8'h28 ||
                paddr == 8'h2c || paddr == 8'h30 || paddr == 8'h34;
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  // ----
  // assertions
  // ----
  a_ready_bound: assert property (s_setup ##1 s_access |-> ##[0:1000] pready)
    else $error("no answer to transfer");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped address not refused");
  a_err_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("mapped address refused");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rxen_reserved: assert property (rd_ok && paddr == 8'h28 |-> prdata[31:1] == 31'h0000_0000)
    else $error("enable reserved bits set");
  a_rx_reserved: assert property (rd_ok && paddr[7:3] == 5'h04 |-> prdata[31:16] == 16'h0000)
    else $error("sample reserved bits set");
  a_res_reserved: assert property (rd_ok && paddr[7:3] == 5'h06 |-> prdata[31:3] == 29'h0000_0000)
    else $error("resolution reserved bits set");
  a_sdo_after_fall: assert property ($changed(link_sdo) |->
    !$past(link_sclk, 2) || !$past(link_sclk, 3) || !$past(link_sclk, 4) || !$past(link_sclk, 5))
    else $error("sdo changed without bit clock fall");
endmodule // ssa_props

bind ssa_top ssa_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_sclk(link_sclk),
  .word_select_line(word_select_line), .link_sdi(link_sdi), .link_sdo(link_sdo));

// [verification/ssa_codec.sv]
// codec partner: frames of bit clock, word select and receive data, captures transmit data
// assumes the bench calls frame; the bit clock stands low between frames
`timescale 1ns/1ps
module ssa_codec (
  output reg link_sclk, // bit clock, 125 ns, idle low
  output reg word_select_line, // low left, high right
  output reg link_sdi, // serial data to device
  input wire link_sdo // serial data from device
);
  integer j;
  // idle levels
  initial begin
    link_sclk = 1'b0;
    word_select_line = 1'b0;
    link_sdi = 1'b0;
  end
  // ----
  // two lead bits, then left and right words, msb first, ws one bit early
  // ----
  task frame(input [15:0] l, input [15:0] r, output [15:0] gl, output [15:0] gr);
    begin
      for (j = 0; j < 34; j = j + 1) begin
        word_select_line = (j == 0) || (j >= 17 && j <= 32);
        link_sdi = (j >= 18) ? r[33-j] : (j >= 2) ? l[17-j] : ~link_sdi;
        #62.5 link_sclk = 1'b1;
        if (j >= 18) gr[33-j] = link_sdo;
        else if (j >= 2) gl[17-j] = link_sdo;
        #62.5 link_sclk = 1'b0;
      end
      link_sdi = ~link_sdi;
    end
  endtask
endmodule // ssa_codec

// [verification/ssa_top_test.sv]
// testbench of ssa_top: apb tasks, codec frames, compared samples and registers
// assumes ssa_top, ssa_codec and the bound checker are compiled before it
`timescale 1ns/1ps
module ssa_top_test;
  reg pclk, presetn, psel, penable, pwrite, err;
  reg [7:0] paddr;
  reg [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, link_sclk, word_select_line, link_sdi, link_sdo;
  reg [15:0] gl, gr, v;
  integer error_cnt, total_checks, i, k;
  ssa_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_sclk(link_sclk),
    .word_select_line(word_select_line), .link_sdi(link_sdi), .link_sdo(link_sdo));
  ssa_codec u_codec (.link_sclk(link_sclk), .word_select_line(word_select_line), .link_sdi(link_sdi),
    .link_sdo(link_sdo));
  // 100 mhz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ----
  // compare, verdict, expected samples
  // ----
  task check(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("mismatches %0d, checks %0d", error_cnt, total_checks);
      if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  function [31:0] rx_exp(input [2:0] c, input [15:0] s);
    case (c)
      3'h1: rx_exp = {20'h0_0000, s[15:4]};
      3'h3: rx_exp = {16'h0000, s[11:0], 4'h0};
      3'h4: rx_exp = {16'h0000, s[7:0], 8'h00};
      3'h5: rx_exp = 32'h0000_0000;
      default: rx_exp = {16'h0000, s};
    endcase
  endfunction
  function [15:0] tx_exp(input [2:0] c, input [15:0] s);
    case (c)
      3'h1: tx_exp = {s[11:0], 4'h0};
      3'h3: tx_exp = {4'h0, s[15:4]};
      3'h4: tx_exp = {8'h00, s[15:8]};
      3'h5: tx_exp = 16'h0000;
      default: tx_exp = s;
    endcase
  endfunction
  // ----
  // apb transfer and codec frame
  // ----
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 2000) begin
        k = k + 1;
        @(posedge pclk);
      end
      if (k == 2000) begin
        check(0, 1);
        wrap_up;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task run(input [15:0] l, input [15:0] r);
    begin
      u_codec.frame(l, r, gl, gr);
      @(posedge pclk);
    end
  endtask
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    error_cnt = 0;
    total_checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 8'h20, 0); check(rd, 0);
    apb(0, 8'h24, 0); check(rd, 0);
    apb(0, 8'h28, 0); check(rd, 0);
    apb(0, 8'h30, 0); check(rd, 32'h0000_0002);
    apb(0, 8'h00, 0); check(err, 1);
    apb(1, 8'h20, 32'hffff_a5c3);
    apb(1, 8'h24, 32'h0000_3c5a);
    run(16'h1234, 16'h8765);
    check(gl, 16'ha5c3);
    check(gr, 16'h3c5a);
    apb(0, 8'h20, 0); check(rd, 0);
    apb(0, 8'h24, 0); check(rd, 0);
    apb(1, 8'h28, 32'hffff_ffff);
    apb(0, 8'h28, 0); check(rd, 1);
    // span field read back, then back to 16 bits for the frames
    apb(1, 8'h10, 32'h0000_0010);
    apb(0, 8'h10, 0); check(rd, 32'h0000_0010);
    apb(1, 8'h10, 0);
    // every resolution code on both directions
    for (i = 0; i < 6; i = i + 1) begin
      v = 16'hc3a6 ^ {4{i[3:0]}};
      apb(1, 8'h30, i);
      apb(1, 8'h34, i);
      apb(1, 8'h20, {16'h0000, ~v});
      apb(1, 8'h24, {16'h0000, v});
      run(v, ~v);
      apb(0, 8'h20, 0); check(rd, rx_exp(i[2:0], v));
      apb(0, 8'h24, 0); check(rd, rx_exp(i[2:0], ~v));
      check(gl, tx_exp(i[2:0], ~v));
      check(gr, tx_exp(i[2:0], v));
    end
    apb(1, 8'h30, 2);
    apb(1, 8'h34, 2);
    // closing ws fall of each frame found the fifo empty: underrun set
    apb(0, 8'h2c, 0); check(rd, 32'h0000_0002);
    apb(1, 8'h2c, 32'h0000_0003);
    // fill the fifo, then drain it in order
    for (i = 0; i < 16; i = i + 1) begin
      apb(1, 8'h20, i);
      apb(1, 8'h24, i + 256);
    end
    apb(0, 8'h2c, 0); check(rd, 32'h0000_1004);
    // each frame pops twice: at its lead ws fall and at its closing ws fall
    for (i = 0; i < 8; i = i + 1) begin
      run(16'h0f0f, 16'hf0f0);
      check(gl, 2 * i);
      check(gr, 2 * i + 256);
    end
    apb(0, 8'h2c, 0); check(rd, 0);
    run(16'h5555, 16'haaaa);
    check({gl, gr}, 0);
    apb(0, 8'h24, 0); check(rd, 32'h0000_aaaa);
    apb(0, 8'h2c, 0); check(rd, 32'h0000_0002);
    wrap_up;
  end
endmodule // ssa_top_test
